// ---- src/sar_cfg.svh ----
// Timing counts and field constants of the converter sequencer
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

`define SAR_NBITS 8
`define SAR_CLK_DIV 2
`define SAR_CONV_PIN_CYCLES 20
`define SAR_CONV_INT_CYCLES 10
`define SAR_HOLD_EDGE 3
`define SAR_FIRST_DECIDE_TICK 3
`define SAR_FIFO_DEPTH 8
`define SAR_CODE_MID 8'h80
`define SAR_CODE_ZERO 8'h00

`endif

// ---- src/sar_pkg.sv ----
// Types of the converter sequencer
package sar_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_REARM = 2'b10
    } conv_state_t;
endpackage

// ---- src/result_fifo.sv ----
// Result FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0
                    : wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0
                    : rptr_reg + 1'b1;
            end
        end
    end

    // Fill level
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- src/sar_adc_sample_clock_control.sv ----
// Sampler, clock and conversion sequencing of an 8-bit SAR converter
//
// Behaviour
// - Fast variant holds the input on third pin falling edge after start.
// - Sampler tracks at conversion start and again once conversion completes.
// - Slow variant samples eight times, once before each bit decision.
// - Internal conversion clock is the clock-pin signal divided by two.
// - A conversion lasts 20 clock-pin cycles, ten internal cycles.
// - With on-chip oscillator, clock pin is clamped high outside conversions.
// - Between conversions pin activity is ignored, internal clock stopped.
// - In the fast variant, bipolar use presents the result in offset binary coding.
// - At conversion end busy goes high and the output latch is loaded.
`timescale 1ns/100ps
`default_nettype none
`include "sar_cfg.svh"
module sar_adc_sample_clock_control #(
    parameter bit FAST_VARIANT = 1'b1,
    parameter int NBITS = `SAR_NBITS,
    parameter int FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic clk_pin_i,
    output logic clk_pin_o,
    output logic clk_pin_oe,
    input wire logic osc_internal,
    input wire logic bipolar,
    input wire logic comp_above,
    output logic [NBITS-1:0] dac_code,
    output logic sample_switch,
    output logic busy_n,
    output logic [NBITS-1:0] data_o,
    output logic data_oe,
    output logic offset_binary
);
    localparam logic [4:0] CONV_EDGES = 5'(`SAR_CONV_PIN_CYCLES);
    localparam logic [4:0] HOLD_EDGE = 5'(`SAR_HOLD_EDGE);
    localparam logic [3:0] INT_CYCLES = 4'(`SAR_CONV_INT_CYCLES);
    localparam logic [3:0] FIRST_TICK = 4'(`SAR_FIRST_DECIDE_TICK);
    localparam logic [NBITS-1:0] CODE_MID = NBITS'(`SAR_CODE_MID);

    sar_pkg::conv_state_t state_reg;
    logic [2:0] clk_sync_reg;
    logic [2:0] cs_sync_reg;
    logic [2:0] rd_sync_reg;
    logic [2:0] cmp_sync_reg;
    logic clk_lvl_reg;
    logic cs_lvl_reg;
    logic rd_lvl_reg;
    logic cmp_lvl_reg;
    logic pin_fall;
    logic access;
    logic start;
    logic div_reg;
    logic int_tick;
    logic [4:0] edge_cnt_reg;
    logic [3:0] tick_cnt_reg;
    logic [4:0] edge_next;
    logic [3:0] tick_next;
    logic [NBITS-1:0] code_reg;
    logic [NBITS-1:0] trial_reg;
    logic conv_end;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [NBITS-1:0] fifo_out_data;
    logic [NBITS-1:0] latch_reg;
    logic decide;
    logic [NBITS-1:0] decided;

    // Three-stage pin synchronisers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_sync_reg <= 3'h7;
            cs_sync_reg <= 3'h7;
            rd_sync_reg <= 3'h7;
            cmp_sync_reg <= 3'h0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[1:0], clk_pin_i};
            cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
            rd_sync_reg <= {rd_sync_reg[1:0], rd_n};
            cmp_sync_reg <= {cmp_sync_reg[1:0], comp_above};
        end
    end

    // Filtered levels, change taken when stages two and three agree
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_lvl_reg <= 1'b1;
            cs_lvl_reg <= 1'b1;
            rd_lvl_reg <= 1'b1;
            cmp_lvl_reg <= 1'b0;
        end else begin
            if (clk_sync_reg[1] == clk_sync_reg[2]) begin
                clk_lvl_reg <= clk_sync_reg[2];
            end
            if (cs_sync_reg[1] == cs_sync_reg[2]) begin
                cs_lvl_reg <= cs_sync_reg[2];
            end
            if (rd_sync_reg[1] == rd_sync_reg[2]) begin
                rd_lvl_reg <= rd_sync_reg[2];
            end
            if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
                cmp_lvl_reg <= cmp_sync_reg[2];
            end
        end
    end

    assign pin_fall = clk_lvl_reg && (clk_sync_reg[1] == 1'b0)
        && (clk_sync_reg[2] == 1'b0) && (state_reg == sar_pkg::ST_CONV);
    assign access = !cs_lvl_reg && !rd_lvl_reg;
    assign start = access && (state_reg == sar_pkg::ST_IDLE) && fifo_in_ready;
    assign int_tick = pin_fall && div_reg;
    assign edge_next = edge_cnt_reg + 5'h01;
    assign tick_next = tick_cnt_reg + 4'h1;
    assign conv_end = pin_fall && (edge_next == CONV_EDGES);
    assign decide = int_tick && (tick_next >= FIRST_TICK);
    assign decided = cmp_lvl_reg ? code_reg : (code_reg & ~trial_reg);

    // Conversion state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= sar_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                sar_pkg::ST_IDLE: begin
                    if (start) begin
                        state_reg <= sar_pkg::ST_CONV;
                    end
                end
                sar_pkg::ST_CONV: begin
                    if (conv_end) begin
                        state_reg <= sar_pkg::ST_REARM;
                    end
                end
                sar_pkg::ST_REARM: begin
                    if (!access) begin
                        state_reg <= sar_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= sar_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || start) begin
            div_reg <= 1'b0;
            edge_cnt_reg <= 5'h00;
            tick_cnt_reg <= 4'h0;
        end else if (pin_fall) begin
            div_reg <= !div_reg;
            edge_cnt_reg <= edge_next;
            if (div_reg) begin
                tick_cnt_reg <= tick_next;
            end
        end
    end

    // Successive approximation register
    always_ff @(posedge mclk) begin
        if (!rst_n || start) begin
            code_reg <= CODE_MID;
            trial_reg <= CODE_MID;
        end else if (decide) begin
            code_reg <= decided | (trial_reg >> 1);
            trial_reg <= trial_reg >> 1;
        end
    end

    assign dac_code = code_reg;

    // Sampler switch, high while tracking
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sample_switch <= 1'b1;
        end else if (start || conv_end) begin
            // track at start and after end
            sample_switch <= 1'b1;
        end else if (pin_fall && FAST_VARIANT) begin
            if (edge_next == HOLD_EDGE) begin
                sample_switch <= 1'b0;
            end
        end else if (pin_fall) begin
            if (edge_next[0] && edge_next > HOLD_EDGE) begin
                sample_switch <= 1'b0;
            end else if (!edge_next[0] && tick_next >= 4'h2) begin
                sample_switch <= 1'b1;
            end
        end
    end

    // busy low in conversion, high at end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busy_n <= 1'b1;
        end else if (start) begin
            busy_n <= 1'b0;
        end else if (conv_end) begin
            busy_n <= 1'b1;
        end
    end

    // clamp clock pin high outside conversion
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_pin_o <= 1'b1;
            clk_pin_oe <= 1'b0;
        end else begin
            clk_pin_o <= 1'b1;
            clk_pin_oe <= osc_internal && !start
                && (state_reg != sar_pkg::ST_CONV || conv_end);
        end
    end

    result_fifo #(
        .WIDTH(NBITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(conv_end),
        .in_ready(fifo_in_ready),
        .in_data(decided),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // latch loads once a result is ready
    assign fifo_pop = fifo_out_valid;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            latch_reg <= NBITS'(`SAR_CODE_ZERO);
        end else if (fifo_pop) begin
            latch_reg <= fifo_out_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            data_o <= NBITS'(`SAR_CODE_ZERO);
            data_oe <= 1'b0;
        end else begin
            data_o <= fifo_pop ? fifo_out_data : latch_reg;
            data_oe <= access;
        end
    end

    // bipolar coding flag, code already offset binary
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            offset_binary <= 1'b0;
        end else begin
            offset_binary <= bipolar && FAST_VARIANT;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_hold_third;
        FAST_VARIANT && pin_fall && edge_next == HOLD_EDGE |=> !sample_switch;
    endproperty
    a_hold_third: assert property (p_hold_third)
        else $error("sampler not holding on third edge");

    property p_no_early_hold;
        FAST_VARIANT && state_reg == sar_pkg::ST_CONV
            && edge_cnt_reg < HOLD_EDGE && !pin_fall |=> sample_switch;
    endproperty
    a_no_early_hold: assert property (p_no_early_hold)
        else $error("sampler held before third edge");

    property p_track_after_end;
        conv_end |=> sample_switch && busy_n;
    endproperty
    a_track_after_end: assert property (p_track_after_end)
        else $error("sampler not tracking after conversion");

    property p_slow_sample;
        !FAST_VARIANT && decide |-> !sample_switch;
    endproperty
    a_slow_sample: assert property (p_slow_sample)
        else $error("slow variant not holding at decision");

    property p_tick_every_two;
        int_tick |-> edge_next[0] == 1'b0;
    endproperty
    a_tick_every_two: assert property (p_tick_every_two)
        else $error("internal tick not on even edge");

    property p_len;
        conv_end |-> tick_next == INT_CYCLES;
    endproperty
    a_len: assert property (p_len)
        else $error("conversion not ten internal cycles");

    property p_clamp;
        osc_internal && state_reg == sar_pkg::ST_REARM |=> clk_pin_oe;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("oscillator not clamped after conversion");

    property p_ignore_clk;
        state_reg != sar_pkg::ST_CONV && !start |=> $stable(edge_cnt_reg);
    endproperty
    a_ignore_clk: assert property (p_ignore_clk)
        else $error("clock edge counted between conversions");

    property p_bus;
        1'b1 |=> data_oe == $past(access);
    endproperty
    a_bus: assert property (p_bus)
        else $error("data not driven during access");

    property p_busy_start;
        start |=> !busy_n [*2];
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy not low after start");
endmodule
`default_nettype wire

// ---- verif/cpu_bus_model.sv ----
// Processor bus, clock source and comparator facing the converter
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
    input wire logic mclk,
    input wire logic clk_pin_o,
    input wire logic clk_pin_oe,
    input wire logic [7:0] dac_code,
    input wire logic [7:0] data_o,
    input wire logic data_oe,
    input wire logic [7:0] analog_level,
    output logic cs_n,
    output logic rd_n,
    output logic clk_pin_i,
    output logic comp_above
);
    logic src_clk = 1'b1;
    logic [1:0] div_cnt = 2'h0;
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
    end
    always @(posedge mclk) begin
        div_cnt <= div_cnt + 2'h1;
        if (div_cnt == 2'h3) begin
            src_clk <= ~src_clk;
        end
    end
    assign clk_pin_i = clk_pin_oe ? clk_pin_o : src_clk;
    assign comp_above = analog_level >= dac_code;
    task automatic cpu_read(input int hold, output logic [7:0] d);
        int n;
        n = 0;
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        @(posedge mclk);
        while (data_oe !== 1'b1 && n < 20) begin
            n++;
            @(posedge mclk);
        end
        d = data_o;
        repeat (hold) @(posedge mclk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_sar_adc_sample_clock_control.sv ----
// Testbench of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_sar_adc_sample_clock_control;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_internal = 1'b0;
    logic bipolar = 1'b0;
    logic cs_n, rd_n, clk_pin_i, clk_pin_o, clk_pin_oe, comp_above;
    logic sample_switch, busy_n, data_oe, offset_binary, slow_sw, slow_ob;
    logic [7:0] dac_code, data_o, dac_q;
    logic [7:0] level = 8'h00;
    logic [7:0] prev = 8'h00;
    logic pin_q, sw_q, slw_q, busy_q, sw_start, sw_end;
    logic odd_dac = 1'b0;
    logic oe_bad = 1'b0;
    int fall_cnt = 0, sw_at = 0, busy_at = 0, slow_n = 0, slow_at = 0;
    int fail_count = 0, n_checks = 0;
    always #25 mclk = ~mclk;
    sar_adc_sample_clock_control i_dut (.mclk, .rst_n, .cs_n, .rd_n,
        .clk_pin_i, .clk_pin_o, .clk_pin_oe, .osc_internal, .bipolar,
        .comp_above, .dac_code, .sample_switch, .busy_n, .data_o, .data_oe,
        .offset_binary);
    sar_adc_sample_clock_control #(.FAST_VARIANT(1'b0)) i_slow (.mclk,
        .rst_n, .cs_n, .rd_n, .clk_pin_i, .clk_pin_o(), .clk_pin_oe(),
        .osc_internal, .bipolar, .comp_above, .dac_code(),
        .sample_switch(slow_sw), .busy_n(), .data_o(), .data_oe(),
        .offset_binary(slow_ob));
    cpu_bus_model i_cpu (.mclk, .clk_pin_o, .clk_pin_oe, .dac_code, .data_o,
        .data_oe, .analog_level(level), .cs_n, .rd_n, .clk_pin_i,
        .comp_above);
    // Pin edge counts and event stamps
    always @(posedge mclk) begin
        pin_q <= clk_pin_i;
        sw_q <= sample_switch;
        slw_q <= slow_sw;
        busy_q <= busy_n;
        dac_q <= dac_code;
        if (busy_n === 1'b1 && cs_n === 1'b1) begin
            fall_cnt <= 0;
            slow_n <= 0;
        end else begin
            if (pin_q === 1'b1 && clk_pin_i === 1'b0) fall_cnt <= fall_cnt + 1;
            if (slw_q === 1'b1 && slow_sw === 1'b0) slow_n <= slow_n + 1;
        end
        if (sw_q === 1'b1 && sample_switch === 1'b0) sw_at <= fall_cnt;
        if (busy_q === 1'b1 && busy_n === 1'b0) sw_start <= sample_switch;
        if (busy_q === 1'b0 && busy_n === 1'b1) begin
            busy_at <= fall_cnt;
            slow_at <= slow_n;
            sw_end <= sample_switch;
        end
        if (busy_n === 1'b0 && dac_code !== dac_q && fall_cnt[0]) odd_dac <= 1;
        if (busy_q === 1'b0 && busy_n === 1'b0
            && clk_pin_oe !== 1'b0) oe_bad <= 1;
    end
    task automatic check(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic convert(input logic [7:0] lv, input logic timed);
        logic [7:0] d;
        int n;
        n = 0;
        level <= lv;
        if (timed) @(negedge clk_pin_i);
        @(posedge mclk);
        i_cpu.cpu_read(2, d);
        check("old data", prev, d);
        check("busy low", 0, busy_n);
        check("bus on", 1, data_oe);
        while (busy_n !== 1'b1 && n < 400) begin
            n++;
            @(posedge mclk);
        end
        check("conv done", 1, busy_n);
        repeat (2) @(posedge mclk);
        if (timed) begin
            check("hold edge", 3, sw_at);
            check("conv falls", 20, busy_at);
            check("int clock", 0, odd_dac);
        end
        check("slow holds", 8, slow_at);
        check("track start", 1, sw_start);
        check("track end", 1, sw_end);
        check("bus off", 0, data_oe);
        check("coding flag", bipolar, offset_binary);
        check("slow flag", 0, slow_ob);
        prev = lv;
    endtask
    task automatic t_reset;
        repeat (2) @(posedge mclk);
        check("busy", 1, busy_n);
        check("switch", 1, sample_switch);
        check("clamp", 0, clk_pin_oe);
        check("bus", 0, data_oe);
        check("trial", 8'h80, dac_code);
        $display("test reset done");
    endtask
    task automatic t_codes;
        logic [7:0] lv [4];
        lv = '{8'h00, 8'hFF, 8'h80, 8'h5A};
        for (int i = 0; i < 4; i++) begin
            bipolar <= i[0];
            convert(lv[i], 1'b1);
        end
        $display("test codes done");
    endtask
    task automatic t_hold;
        logic [7:0] d;
        level <= 8'hC3;
        @(posedge mclk);
        i_cpu.cpu_read(300, d);
        check("held old data", prev, d);
        check("new data", 8'hC3, data_o);
        check("bus held", 1, data_oe);
        check("no restart", 1, busy_n);
        prev = 8'hC3;
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            check("idle busy", 1, busy_n);
            check("idle switch", 1, sample_switch);
        end
        $display("test hold done");
    endtask
    task automatic t_osc;
        osc_internal <= 1'b1;
        repeat (3) @(posedge mclk);
        check("clamp on", 1, clk_pin_oe);
        check("clamp level", 1, clk_pin_o);
        convert(8'h01, 1'b0);
        check("clamp in conv", 0, oe_bad);
        check("clamp again", 1, clk_pin_oe);
        convert(8'h00, 1'b0);
        $display("test oscillator done");
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        $display("[FAIL] watchdog expected done seen hang");
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset;
        t_codes;
        t_hold;
        t_osc;
        print_verdict;
    end
endmodule
`default_nettype wire
